// File: hw/fio_pkg.sv
// Shared constants and types for the forced terminal override block
package fio_pkg;

   localparam int FIO_NUM_IN  = 9;
   localparam int FIO_NUM_OUT = 5;
   localparam int FIO_REG_W   = 16;
   localparam int FIO_ADDR_W  = 8;
   localparam int FIO_DATA_W  = 32;
   localparam int FIO_STRB_W  = FIO_DATA_W / 8;
   localparam int FIO_BYTE_W  = 8;

   localparam logic [FIO_ADDR_W-1:0] FIO_ADDR_SEL     = 8'h00;
   localparam logic [FIO_ADDR_W-1:0] FIO_ADDR_FIN     = 8'h04;
   localparam logic [FIO_ADDR_W-1:0] FIO_ADDR_FOUT    = 8'h08;
   localparam logic [FIO_ADDR_W-1:0] FIO_ADDR_IN_MON  = 8'h0c;
   localparam logic [FIO_ADDR_W-1:0] FIO_ADDR_OUT_MON = 8'h10;
   localparam logic [FIO_ADDR_W-1:0] FIO_ADDR_IN_ACT  = 8'h14;
   localparam logic [FIO_ADDR_W-1:0] FIO_ADDR_OUT_ACT = 8'h18;

   localparam logic [1:0] FIO_RESP_OKAY   = 2'h0;
   localparam logic [1:0] FIO_RESP_SLVERR = 2'h2;

   localparam logic [FIO_REG_W-1:0] FIO_FIN_RST   = 16'h0000;
   localparam logic [FIO_REG_W-1:0] FIO_FOUT_RST  = 16'h0000;
   localparam logic [FIO_REG_W-1:0] FIO_IACT_RST  = 16'h0000;
   localparam logic [FIO_REG_W-1:0] FIO_OACT_RST  = 16'h0000;
   localparam logic [FIO_REG_W-1:0] FIO_IMON_RST  = 16'h0000;
   // Outputs idle at the invalid level of the low-active reset polarity
   localparam logic [FIO_REG_W-1:0] FIO_OTERM_RST = 16'hffff;

   typedef enum logic [1:0] {
      FIO_SEL_NONE = 2'b00,
      FIO_SEL_IN   = 2'b01,
      FIO_SEL_OUT  = 2'b10,
      FIO_SEL_BOTH = 2'b11
   } fio_sel_t;

   typedef struct packed {
      logic                  awvalid;
      logic [FIO_ADDR_W-1:0] awaddr;
      logic                  wvalid;
      logic [FIO_DATA_W-1:0] wdata;
      logic [FIO_STRB_W-1:0] wstrb;
      logic                  bready;
      logic                  arvalid;
      logic [FIO_ADDR_W-1:0] araddr;
      logic                  rready;
   } fio_axi_req_t;

   typedef struct packed {
      logic                  awready;
      logic                  wready;
      logic                  bvalid;
      logic [1:0]            bresp;
      logic                  arready;
      logic                  rvalid;
      logic [FIO_DATA_W-1:0] rdata;
      logic [1:0]            rresp;
   } fio_axi_rsp_t;

endpackage

// File: hw/fio_axil_slave.sv
// AXI4-Lite slave front end: one write and one read in flight, registered answers
`timescale 1ns/1ns
`default_nettype none
module fio_axil_slave
   import fio_pkg::*;
(
   input  wire logic                  ref_clk,
   input  wire logic                  rst,
   input  wire fio_axi_req_t          axiReq,
   output var  fio_axi_rsp_t          axiRsp,
   output logic                       wrEn,
   output logic [FIO_ADDR_W-1:0]      wrAddr,
   output logic [FIO_DATA_W-1:0]      wrData,
   output logic [FIO_STRB_W-1:0]      wrStrb,
   input  wire logic                  wrErr,
   output logic                       rdEn,
   output logic [FIO_ADDR_W-1:0]      rdAddr,
   input  wire logic [FIO_DATA_W-1:0] rdData,
   input  wire logic                  rdErr
);

   logic                  awReady_q, wReady_q, awHeld_q, wHeld_q, bValid_q;
   logic                  arReady_q, arHeld_q, rValid_q;
   logic [FIO_ADDR_W-1:0] awAddr_q, arAddr_q;
   logic [FIO_DATA_W-1:0] wData_q, rData_q;
   logic [FIO_STRB_W-1:0] wStrb_q;
   logic [1:0]            bResp_q, rResp_q;

   assign wrEn   = awHeld_q && wHeld_q && !bValid_q;
   assign wrAddr = awAddr_q;
   assign wrData = wData_q;
   assign wrStrb = wStrb_q;
   assign rdEn   = arHeld_q;
   assign rdAddr = arAddr_q;

   // Readies come back only after the response is taken, so one write is in flight
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         awReady_q <= 1'b1;
         wReady_q  <= 1'b1;
         awHeld_q  <= 1'b0;
         wHeld_q   <= 1'b0;
         bValid_q  <= 1'b0;
         awAddr_q  <= '0;
         wData_q   <= '0;
         wStrb_q   <= '0;
         bResp_q   <= FIO_RESP_OKAY;
      end else begin
         if (awReady_q && axiReq.awvalid) begin
            awAddr_q  <= axiReq.awaddr;
            awHeld_q  <= 1'b1;
            awReady_q <= 1'b0;
         end
         if (wReady_q && axiReq.wvalid) begin
            wData_q  <= axiReq.wdata;
            wStrb_q  <= axiReq.wstrb;
            wHeld_q  <= 1'b1;
            wReady_q <= 1'b0;
         end
         if (wrEn) begin
            awHeld_q <= 1'b0;
            wHeld_q  <= 1'b0;
            bValid_q <= 1'b1;
            bResp_q  <= wrErr ? FIO_RESP_SLVERR : FIO_RESP_OKAY;
         end
         if (bValid_q && axiReq.bready) begin
            bValid_q  <= 1'b0;
            awReady_q <= 1'b1;
            wReady_q  <= 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         arReady_q <= 1'b1;
         arHeld_q  <= 1'b0;
         rValid_q  <= 1'b0;
         arAddr_q  <= '0;
         rData_q   <= '0;
         rResp_q   <= FIO_RESP_OKAY;
      end else begin
         if (arReady_q && axiReq.arvalid) begin
            arAddr_q  <= axiReq.araddr;
            arHeld_q  <= 1'b1;
            arReady_q <= 1'b0;
         end
         if (arHeld_q) begin
            arHeld_q <= 1'b0;
            rValid_q <= 1'b1;
            rData_q  <= rdErr ? '0 : rdData;
            rResp_q  <= rdErr ? FIO_RESP_SLVERR : FIO_RESP_OKAY;
         end
         if (rValid_q && axiReq.rready) begin
            rValid_q  <= 1'b0;
            arReady_q <= 1'b1;
         end
      end
   end

   always_comb begin
      axiRsp.awready = awReady_q;
      axiRsp.wready  = wReady_q;
      axiRsp.bvalid  = bValid_q;
      axiRsp.bresp   = bResp_q;
      axiRsp.arready = arReady_q;
      axiRsp.rvalid  = rValid_q;
      axiRsp.rdata   = rData_q;
      axiRsp.rresp   = rResp_q;
   end

endmodule
`default_nettype wire

// File: hw/fio_forced_io_override.sv
// Forced terminal override: register file, terminal muxing, polarity and monitors
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module fio_forced_io_override
   import fio_pkg::*;
#(
   parameter int NUM_IN  = FIO_NUM_IN,
   parameter int NUM_OUT = FIO_NUM_OUT
) (
   input  wire logic               ref_clk,
   input  wire logic               rst,
   input  wire fio_axi_req_t       axiReq,
   output var  fio_axi_rsp_t       axiRsp,
   input  wire logic [NUM_IN-1:0]  inTerm,
   input  wire logic [NUM_IN-1:0]  virtIn,
   input  wire logic [NUM_OUT-1:0] outFuncNormal,
   output logic [NUM_IN-1:0]       inFuncValid,
   output logic [NUM_IN-1:0]       virtFuncValid,
   output logic [NUM_OUT-1:0]      outTerm
);

   logic                  wrEn;
   logic [FIO_ADDR_W-1:0] wrAddr;
   logic [FIO_DATA_W-1:0] wrData;
   logic [FIO_STRB_W-1:0] wrStrb;
   logic                  wrErr;
   logic                  rdEn;
   logic [FIO_ADDR_W-1:0] rdAddr;
   logic [FIO_DATA_W-1:0] rdData;
   logic                  rdErr;
   logic [FIO_DATA_W-1:0] wrMerged;

   fio_sel_t             sel_q;
   logic [NUM_IN-1:0]    forcedIn_q;
   logic [NUM_OUT-1:0]   forcedOut_q;
   logic [NUM_IN-1:0]    inAct_q;
   logic [NUM_OUT-1:0]   outAct_q;
   logic [NUM_IN-1:0]    inMon_q;
   logic [NUM_IN-1:0]    inFunc_q;
   logic [NUM_IN-1:0]    virtFunc_q;
   logic [NUM_OUT-1:0]   outTerm_q;

   logic                 forceIn;
   logic                 forceOut;
   logic [NUM_IN-1:0]    inLvl;
   logic [NUM_IN-1:0]    virtLvl;
   logic [NUM_OUT-1:0]   outValid;
   logic [FIO_REG_W-1:0] inFuncMap;
   logic [FIO_REG_W-1:0] virtFuncMap;
   logic [FIO_REG_W-1:0] outLvlMap;

   fio_axil_slave u_bus (
      .ref_clk (ref_clk),
      .rst     (rst),
      .axiReq  (axiReq),
      .axiRsp  (axiRsp),
      .wrEn    (wrEn),
      .wrAddr  (wrAddr),
      .wrData  (wrData),
      .wrStrb  (wrStrb),
      .wrErr   (wrErr),
      .rdEn    (rdEn),
      .rdAddr  (rdAddr),
      .rdData  (rdData),
      .rdErr   (rdErr)
   );

   // Level to function state, and back: both are the same xnor with the active level
   function automatic logic [FIO_REG_W-1:0] actMap(
      input logic [FIO_REG_W-1:0] lvl,
      input logic [FIO_REG_W-1:0] act
   );
      actMap = ~(lvl ^ act);
   endfunction

   function automatic logic isMapped(input logic [FIO_ADDR_W-1:0] a);
      isMapped = (a == FIO_ADDR_SEL) || (a == FIO_ADDR_FIN) || (a == FIO_ADDR_FOUT)
              || (a == FIO_ADDR_IN_MON) || (a == FIO_ADDR_OUT_MON)
              || (a == FIO_ADDR_IN_ACT) || (a == FIO_ADDR_OUT_ACT);
   endfunction

   function automatic logic [FIO_DATA_W-1:0] applyStrb(
      input logic [FIO_DATA_W-1:0] old,
      input logic [FIO_DATA_W-1:0] data,
      input logic [FIO_STRB_W-1:0] strb
   );
      logic [FIO_DATA_W-1:0] res;
      res = old;
      for (int i = 0; i < FIO_STRB_W; i++) begin
         if (strb[i]) begin
            res[i*FIO_BYTE_W +: FIO_BYTE_W] = data[i*FIO_BYTE_W +: FIO_BYTE_W];
         end
      end
      applyStrb = res;
   endfunction

   // Readback decode, shared by the read port and the byte-lane merge of writes
   function automatic logic [FIO_DATA_W-1:0] regValue(input logic [FIO_ADDR_W-1:0] a);
      logic [FIO_DATA_W-1:0] v;
      v = '0;
      if (a == FIO_ADDR_SEL) begin
         v = FIO_DATA_W'(sel_q);
      end else if (a == FIO_ADDR_FIN) begin
         v = FIO_DATA_W'(forcedIn_q);
      end else if (a == FIO_ADDR_FOUT) begin
         v = FIO_DATA_W'(forcedOut_q);
      end else if (a == FIO_ADDR_IN_MON) begin
         v = FIO_DATA_W'(inMon_q);
      end else if (a == FIO_ADDR_OUT_MON) begin
         v = FIO_DATA_W'(outTerm_q);
      end else if (a == FIO_ADDR_IN_ACT) begin
         v = FIO_DATA_W'(inAct_q);
      end else if (a == FIO_ADDR_OUT_ACT) begin
         v = FIO_DATA_W'(outAct_q);
      end
      regValue = v;
   endfunction

   assign wrErr    = !isMapped(wrAddr);
   assign rdErr    = !isMapped(rdAddr);
   // A process, not an assign: the function reads registers that are not its arguments
   always_comb begin
      rdData = regValue(rdAddr);
   end

   always_comb begin
      wrMerged = applyStrb(regValue(wrAddr), wrData, wrStrb);
   end

   always_comb begin
      forceIn  = 1'b0;
      forceOut = 1'b0;
      unique case (sel_q)
         FIO_SEL_NONE: begin
            forceIn  = 1'b0;
            forceOut = 1'b0;
         end
         FIO_SEL_IN: begin
            forceIn  = 1'b1;
            forceOut = 1'b0;
         end
         FIO_SEL_OUT: begin
            forceIn  = 1'b0;
            forceOut = 1'b1;
         end
         FIO_SEL_BOTH: begin
            forceIn  = 1'b1;
            forceOut = 1'b1;
         end
      endcase
   end

   // Selector is volatile by design: only reset or a zero write leaves forcing
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sel_q <= FIO_SEL_NONE;
      end else if (wrEn && (wrAddr == FIO_ADDR_SEL)) begin
         sel_q <= fio_sel_t'(wrMerged[1:0]);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         forcedIn_q  <= FIO_FIN_RST[NUM_IN-1:0];
         forcedOut_q <= FIO_FOUT_RST[NUM_OUT-1:0];
      end else begin
         if (wrEn && (wrAddr == FIO_ADDR_FIN)) begin
            forcedIn_q <= wrMerged[NUM_IN-1:0];
         end
         if (wrEn && (wrAddr == FIO_ADDR_FOUT)) begin
            forcedOut_q <= wrMerged[NUM_OUT-1:0];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         inAct_q  <= FIO_IACT_RST[NUM_IN-1:0];
         outAct_q <= FIO_OACT_RST[NUM_OUT-1:0];
      end else begin
         if (wrEn && (wrAddr == FIO_ADDR_IN_ACT)) begin
            inAct_q <= wrMerged[NUM_IN-1:0];
         end
         if (wrEn && (wrAddr == FIO_ADDR_OUT_ACT)) begin
            outAct_q <= wrMerged[NUM_OUT-1:0];
         end
      end
   end

   assign inLvl    = forceIn ? forcedIn_q : inTerm;
   assign virtLvl  = forceIn ? forcedIn_q : virtIn;
   assign outValid = forceOut ? forcedOut_q : outFuncNormal;

   assign inFuncMap   = actMap(FIO_REG_W'(inLvl), FIO_REG_W'(inAct_q));
   assign virtFuncMap = actMap(FIO_REG_W'(virtLvl), FIO_REG_W'(inAct_q));
   assign outLvlMap   = actMap(FIO_REG_W'(outValid), FIO_REG_W'(outAct_q));

   // One register stage on every terminal path keeps all outputs glitch free
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         inMon_q    <= FIO_IMON_RST[NUM_IN-1:0];
         inFunc_q   <= FIO_IMON_RST[NUM_IN-1:0];
         virtFunc_q <= FIO_IMON_RST[NUM_IN-1:0];
      end else begin
         inMon_q    <= inLvl;
         inFunc_q   <= inFuncMap[NUM_IN-1:0];
         virtFunc_q <= virtFuncMap[NUM_IN-1:0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         outTerm_q <= FIO_OTERM_RST[NUM_OUT-1:0];
      end else begin
         outTerm_q <= outLvlMap[NUM_OUT-1:0];
      end
   end

   assign inFuncValid   = inFunc_q;
   assign virtFuncValid = virtFunc_q;
   assign outTerm       = outTerm_q;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   chk_sel_decode: assert property (
      (sel_q == FIO_SEL_OUT) |=> (inMon_q == $past(inTerm))
         && (outTerm_q == NUM_OUT'(actMap(FIO_REG_W'($past(forcedOut_q)),
                                           FIO_REG_W'($past(outAct_q))))))
      else $error("selector value 2 must force outputs only");

   chk_in_forced: assert property (
      forceIn |=> (inMon_q == $past(forcedIn_q)))
      else $error("forced input level not taken from forced register");

   chk_in_normal: assert property (
      (sel_q == FIO_SEL_NONE) |=> (inMon_q == $past(inTerm))
         && (virtFunc_q == NUM_IN'(actMap(FIO_REG_W'($past(virtIn)),
                                          FIO_REG_W'($past(inAct_q))))))
      else $error("normal mode input levels not taken from terminals");

   chk_virt_forced: assert property (
      forceIn |=> (virtFunc_q == NUM_IN'(actMap(FIO_REG_W'($past(forcedIn_q)),
                                                FIO_REG_W'($past(inAct_q))))))
      else $error("virtual inputs not forced");

   // The reset value of the function flops is not the mapped value of the reset levels
   chk_in_polarity: assert property (
      !$past(rst) |-> (inFunc_q == NUM_IN'(actMap(FIO_REG_W'(inMon_q),
                                                    FIO_REG_W'($past(inAct_q))))))
      else $error("input function state disagrees with level and active level");

   chk_mon_equal: assert property (
      $past(forceIn) && $stable(forcedIn_q) |-> (inMon_q == forcedIn_q))
      else $error("input monitor differs from forced input register");

   chk_out_forced: assert property (
      (forceOut && $stable(forcedOut_q) && $stable(outAct_q)) [*2]
         |-> (outTerm_q == NUM_OUT'(actMap(FIO_REG_W'(forcedOut_q),
                                           FIO_REG_W'(outAct_q)))))
      else $error("forced outputs not driven from forced output register");

   chk_out_normal: assert property (
      !forceOut |=> (outTerm_q == NUM_OUT'(actMap(FIO_REG_W'($past(outFuncNormal)),
                                                  FIO_REG_W'($past(outAct_q))))))
      else $error("output level polarity wrong in normal mode");

   chk_out_monitor: assert property (
      rdEn && (rdAddr == FIO_ADDR_OUT_MON)
         |=> axiRsp.rvalid && (axiRsp.rdata == FIO_DATA_W'($past(outTerm_q))))
      else $error("output monitor read does not show terminal levels");

   chk_in_monitor: assert property (
      rdEn && (rdAddr == FIO_ADDR_IN_MON)
         |=> axiRsp.rvalid && (axiRsp.rdata == FIO_DATA_W'($past(inMon_q))))
      else $error("input monitor read does not show input levels");

   chk_sel_reset: assert property (
      $past(rst) |-> (sel_q == FIO_SEL_NONE) && (outTerm_q == FIO_OTERM_RST[NUM_OUT-1:0]))
      else $error("device not in normal mode after reset");

   chk_zero_restore: assert property (
      wrEn && (wrAddr == FIO_ADDR_SEL) && wrStrb[0] && (wrData[1:0] == 2'h0)
         |=> !forceIn && !forceOut ##1 (inMon_q == $past(inTerm)))
      else $error("writing zero to selector did not restore normal mode");

   chk_fin_write: assert property (
      wrEn && (wrAddr == FIO_ADDR_FIN) && wrStrb[0] && wrStrb[1]
         |=> (forcedIn_q == $past(wrData[NUM_IN-1:0])))
      else $error("forced input write not applied next cycle");

   chk_fout_write: assert property (
      wrEn && (wrAddr == FIO_ADDR_FOUT) && wrStrb[0]
         |=> (forcedOut_q == $past(wrData[NUM_OUT-1:0])))
      else $error("forced output write not applied next cycle");

   chk_sel_write: assert property (
      wrEn && (wrAddr == FIO_ADDR_SEL) && wrStrb[0]
         |=> (sel_q == fio_sel_t'($past(wrData[1:0]))))
      else $error("selector write not applied next cycle");

   chk_sel_hold: assert property (
      !(wrEn && (wrAddr == FIO_ADDR_SEL)) |=> $stable(sel_q))
      else $error("selector changed without a selector write");

   chk_fin_hold: assert property (
      !(wrEn && (wrAddr == FIO_ADDR_FIN)) |=> $stable(forcedIn_q))
      else $error("forced input register changed without a write");

   chk_fout_hold: assert property (
      !(wrEn && (wrAddr == FIO_ADDR_FOUT)) |=> $stable(forcedOut_q))
      else $error("forced output register changed without a write");

   chk_in_select: assert property (
      (sel_q == FIO_SEL_IN) |=> (inMon_q == $past(forcedIn_q))
         && (outTerm_q == NUM_OUT'(actMap(FIO_REG_W'($past(outFuncNormal)),
                                           FIO_REG_W'($past(outAct_q))))))
      else $error("selector value 1 must force inputs only");

   chk_sel_both: assert property (
      (sel_q == FIO_SEL_BOTH) |=> (inMon_q == $past(forcedIn_q))
         && (outTerm_q == NUM_OUT'(actMap(FIO_REG_W'($past(forcedOut_q)),
                                           FIO_REG_W'($past(outAct_q))))))
      else $error("selector value 3 must force inputs and outputs");

   chk_iact_write: assert property (
      wrEn && (wrAddr == FIO_ADDR_IN_ACT) && wrStrb[0] && wrStrb[1]
         |=> (inAct_q == $past(wrData[NUM_IN-1:0])))
      else $error("input active level write not applied next cycle");

   chk_oact_write: assert property (
      wrEn && (wrAddr == FIO_ADDR_OUT_ACT) && wrStrb[0]
         |=> (outAct_q == $past(wrData[NUM_OUT-1:0])))
      else $error("output active level write not applied next cycle");

endmodule
`default_nettype wire

// File: test/fio_host_model.sv
// Host controller model: drives the input terminals and latches the output terminals
`timescale 1ns/1ns
`default_nettype none
module fio_host_model
   import fio_pkg::*;
(
   input  wire logic [0:0]             ref_clk,
   input  wire logic [FIO_NUM_IN-1:0]  inPattern,
   input  wire logic [FIO_NUM_IN-1:0]  virtPattern,
   input  wire logic [FIO_NUM_OUT-1:0] outTerm,
   output logic [FIO_NUM_IN-1:0]       inTerm,
   output logic [FIO_NUM_IN-1:0]       virtIn,
   output logic [FIO_NUM_OUT-1:0]      seenOut
);
   // Levels move just after the edge, as a real host output stage would
   always_ff @(posedge ref_clk) begin
      inTerm  <= inPattern;
      virtIn  <= virtPattern;
      seenOut <= outTerm;
   end
endmodule
`default_nettype wire

// File: test/tb_top.sv
// Self-checking bench for the forced terminal override block
`timescale 1ns/1ns
`default_nettype none
module tb_top
   import fio_pkg::*;
;
   logic                   ref_clk;
   logic                   rst;
   fio_axi_req_t           axiReq;
   fio_axi_rsp_t           axiRsp;
   logic [FIO_NUM_IN-1:0]  inPattern, virtPattern, inTerm, virtIn, inFuncValid, virtFuncValid;
   logic [FIO_NUM_IN-1:0]  lvl, vLvl, iAct, expIn, expVirt;
   logic [FIO_NUM_OUT-1:0] outFuncNormal, outTerm, seenOut, oAct, oVal, oLvl;
   logic [1:0]             sel;
   logic [31:0]            rdVal;
   logic [1:0]             respVal;
   logic [7:0]             rstAddr [6];
   int                     n_errors;
   int                     n_tests;

   fio_forced_io_override uut (
      .ref_clk(ref_clk), .rst(rst), .axiReq(axiReq), .axiRsp(axiRsp),
      .inTerm(inTerm), .virtIn(virtIn), .outFuncNormal(outFuncNormal),
      .inFuncValid(inFuncValid), .virtFuncValid(virtFuncValid), .outTerm(outTerm)
   );

   fio_host_model host (
      .ref_clk(ref_clk), .inPattern(inPattern), .virtPattern(virtPattern),
      .outTerm(outTerm), .inTerm(inTerm), .virtIn(virtIn), .seenOut(seenOut)
   );

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Ready is sampled mid-cycle; the transfer happens at the following rising edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er,
                     input logic [3:0] st = 4'hf);
      logic pa, pw, ta, tw, done;
      @(posedge ref_clk);
      axiReq.awaddr  <= a;
      axiReq.wdata   <= d;
      axiReq.wstrb   <= st;
      axiReq.awvalid <= 1'b1;
      axiReq.wvalid  <= 1'b1;
      axiReq.bready  <= 1'b1;
      pa = 1'b1;
      pw = 1'b1;
      done = 1'b0;
      while (pa || pw) begin
         @(negedge ref_clk);
         ta = pa && axiRsp.awready === 1'b1;
         tw = pw && axiRsp.wready === 1'b1;
         @(posedge ref_clk);
         if (ta) begin
            axiReq.awvalid <= 1'b0;
            pa = 1'b0;
         end
         if (tw) begin
            axiReq.wvalid <= 1'b0;
            pw = 1'b0;
         end
      end
      while (!done) begin
         @(negedge ref_clk);
         done = axiRsp.bvalid === 1'b1;
         respVal = axiRsp.bresp;
         @(posedge ref_clk);
      end
      axiReq.bready <= 1'b0;
      check("write response", 32'(respVal), 32'(er));
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er,
                     input string nm);
      logic done;
      @(posedge ref_clk);
      axiReq.araddr  <= a;
      axiReq.arvalid <= 1'b1;
      axiReq.rready  <= 1'b1;
      done = 1'b0;
      while (!done) begin
         @(negedge ref_clk);
         done = axiRsp.arready === 1'b1;
         @(posedge ref_clk);
      end
      axiReq.arvalid <= 1'b0;
      done = 1'b0;
      while (!done) begin
         @(negedge ref_clk);
         done = axiRsp.rvalid === 1'b1;
         rdVal = axiRsp.rdata;
         respVal = axiRsp.rresp;
         @(posedge ref_clk);
      end
      axiReq.rready <= 1'b0;
      check(nm, rdVal, exp);
      check("read response", 32'(respVal), 32'(er));
   endtask

   initial begin
      repeat (20000) @(posedge ref_clk);
      n_errors++;
      $display("watchdog expired");
      finish_test();
   end

   initial begin
      rst = 1'b1;
      axiReq = '0;
      inPattern = '0;
      virtPattern = '0;
      outFuncNormal = '0;
      n_errors = 0;
      n_tests = 0;
      rstAddr = '{FIO_ADDR_SEL, FIO_ADDR_FIN, FIO_ADDR_FOUT, FIO_ADDR_IN_ACT,
                  FIO_ADDR_OUT_ACT, FIO_ADDR_IN_MON};
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      @(negedge ref_clk);
      check("outTerm", 32'(outTerm), 32'h1f);
      foreach (rstAddr[i]) begin
         rd(rstAddr[i], 32'h0, FIO_RESP_OKAY, "reset value");
      end
      rd(FIO_ADDR_OUT_MON, 32'h1f, FIO_RESP_OKAY, "outMon");
      $display("test reset values done");

      // Unmapped place refuses, monitor ignores writes
      wr(8'h40, 32'h3, FIO_RESP_SLVERR);
      rd(8'h40, 32'h0, FIO_RESP_SLVERR, "unmapped");
      wr(FIO_ADDR_IN_MON, 32'h1ff, FIO_RESP_OKAY);
      rd(FIO_ADDR_IN_MON, 32'h0, FIO_RESP_OKAY, "inMon");
      $display("test unmapped and read-only done");

      @(posedge ref_clk);
      inPattern <= 9'h0a5;
      virtPattern <= 9'h03c;
      outFuncNormal <= 5'h05;
      wr(FIO_ADDR_FIN, 32'h1fe, FIO_RESP_OKAY);
      wr(FIO_ADDR_FOUT, 32'h1e, FIO_RESP_OKAY);
      rd(FIO_ADDR_FIN, 32'h1fe, FIO_RESP_OKAY, "forcedIn");
      rd(FIO_ADDR_FOUT, 32'h1e, FIO_RESP_OKAY, "forcedOut");
      for (int act = 0; act < 2; act++) begin
         iAct = (act != 0) ? 9'h1ff : 9'h000;
         oAct = (act != 0) ? 5'h1f : 5'h00;
         wr(FIO_ADDR_IN_ACT, 32'(iAct), FIO_RESP_OKAY);
         wr(FIO_ADDR_OUT_ACT, 32'(oAct), FIO_RESP_OKAY);
         for (int s = 0; s < 4; s++) begin
            sel = s[1:0];
            lvl = sel[0] ? 9'h1fe : 9'h0a5;
            vLvl = sel[0] ? 9'h1fe : 9'h03c;
            oVal = sel[1] ? 5'h1e : 5'h05;
            expIn = ~(lvl ^ iAct);
            expVirt = ~(vLvl ^ iAct);
            oLvl = ~(oVal ^ oAct);
            wr(FIO_ADDR_SEL, {30'h0, sel}, FIO_RESP_OKAY);
            // On the falling edge after the write response the terminals must already follow
            @(negedge ref_clk);
            check("inFuncValid", 32'(inFuncValid), 32'(expIn));
            check("virtFuncValid", 32'(virtFuncValid), 32'(expVirt));
            check("outTerm", 32'(outTerm), 32'(oLvl));
            rd(FIO_ADDR_SEL, 32'(sel), FIO_RESP_OKAY, "select");
            rd(FIO_ADDR_IN_MON, 32'(lvl), FIO_RESP_OKAY, "inMon");
            rd(FIO_ADDR_OUT_MON, 32'(oLvl), FIO_RESP_OKAY, "outMon");
            check("seenOut", 32'(seenOut), 32'(oLvl));
            $display("test select %0d active %0d done", s, act);
         end
      end

      // Byte lanes: bit 8 of the forced input levels lives in the second lane
      wr(FIO_ADDR_FIN, 32'h0ff, FIO_RESP_OKAY, 4'h1);
      rd(FIO_ADDR_FIN, 32'h1ff, FIO_RESP_OKAY, "forcedIn");
      wr(FIO_ADDR_FIN, 32'h0, FIO_RESP_OKAY, 4'h2);
      rd(FIO_ADDR_FIN, 32'h0ff, FIO_RESP_OKAY, "forcedIn");
      rd(FIO_ADDR_IN_MON, 32'h0ff, FIO_RESP_OKAY, "inMon");
      $display("test byte lanes done");

      // Reset in mid-run drops the forcing selection
      @(posedge ref_clk);
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (3) @(negedge ref_clk);
      check("outTerm", 32'(outTerm), 32'h1a);
      check("inFuncValid", 32'(inFuncValid), 32'h15a);
      rd(FIO_ADDR_SEL, 32'h0, FIO_RESP_OKAY, "select");
      $display("test reset in mid-run done");
      finish_test();
   end
endmodule
`default_nettype wire
